// ### rtl/cm_block_fill.sv
// connection memory block fill controller with avalon-mm slave
// Function
// [R1] copy fill value into every location
// [R2] automatic fill of zeros after power-up
// [R3] value captured at start, later writes ignored
// [R4] writing key starts a fill
// [R5] request during running fill is discarded
// [R6] trigger read bit 0 shows block fill
// [R7] trigger read bit 1 shows reset fill
// [R8] trigger read bits 31..2 are zero
// [R9] memory access during fill gives bus fault
// [R10] tdm outputs high impedance during fill
// [R11] non-key write changes nothing
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module cm_block_fill
    import fill_pkg::*;
#(
    parameter int DEPTH  = 32768,
    parameter int CYCLES = FILL_CYCLES
)(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // avalon-mm slave
    input  wire logic [23:0]          address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    input  wire logic [3:0]           byteenable,
    output logic      [31:0]          readdata,
    output logic      [1:0]           response,
    output logic                      waitrequest,
    // connection memory write port
    output fill_pkg::cm_write_t       cm_wr,
    // tdm output control, fault and interrupt
    output logic                      tdm_hiz,
    output logic                      bus_fault_out,
    output logic                      irq
);
    import fill_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PACE_W = 16;

    // refuse parameters the logic cannot serve
    if (DEPTH < 2 || DEPTH > 32768)
    begin : g_depth_bad
        $error("DEPTH out of range");
    end
    if (CYCLES < 1 || CYCLES / DEPTH >= 2 ** PACE_W)
    begin : g_cycles_bad
        $error("CYCLES out of range");
    end

    // spread the writes so the whole fill spans CYCLES;
    // at least one cycle per write, so a short CYCLES stretches the fill
    localparam int PACE = (CYCLES >= DEPTH) ? CYCLES / DEPTH : 1;

    fill_state_t       state;
    logic [31:0]       fill_value;
    logic [31:0]       fill_word;
    logic [AW-1:0]     fill_addr;
    logic [PACE_W-1:0] pace_cnt;
    logic              reset_busy;
    logic              block_busy;
    logic              fill_last;
    logic              fill_done;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_set;
    logic              start_req;
    logic              bus_req;
    logic              acc_fault;
    logic              hit_value;
    logic              hit_trig;
    logic              hit_stat;
    logic              hit_mask;
    logic              hit_mem;
    logic [31:0]       wmask;

    assign bus_req = (read || write) && waitrequest && clk_en;

    // byte lane mask from byteenable
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            wmask[i*8 +: 8] = {8{byteenable[i]}};
    end

    // address decoding
    always_comb
    begin
        hit_value = 1'b0;
        hit_trig  = 1'b0;
        hit_stat  = 1'b0;
        hit_mask  = 1'b0;
        hit_mem   = 1'b0;
        if (address == OFS_FILL_VALUE)
            hit_value = 1'b1;
        else if (address == OFS_FILL_TRIG)
            hit_trig = 1'b1;
        else if (address == OFS_IRQ_STATUS)
            hit_stat = 1'b1;
        else if (address == OFS_IRQ_MASK)
            hit_mask = 1'b1;
        else if (address == OFS_MEM_ACCESS)
            hit_mem = 1'b1;
    end

    // key write while idle starts a fill
    assign start_req = bus_req && write && hit_trig
                       && writedata == FILL_KEY     // R4 R11
                       && state == ST_IDLE;         // R5
    assign acc_fault = bus_req && hit_mem
                       && (state != ST_IDLE);       // R9
    assign fill_last = (fill_addr == AW'(DEPTH - 1))
                       && (pace_cnt == '0);
    assign fill_done = state == ST_FILL && fill_last;

    // fill value register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            fill_value <= FILL_RESET_VAL;           // R2
        else if (clk_en && bus_req && write && hit_value)
            fill_value <= (fill_value & ~wmask) | (writedata & wmask);
    end

    // fill sequencer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= ST_FILL;                  // R2
            fill_word  <= FILL_RESET_VAL;
            fill_addr  <= '0;
            pace_cnt   <= PACE_W'(PACE - 1);
            reset_busy <= 1'b1;
            block_busy <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start_req)
                    begin
                        state      <= ST_FILL;
                        fill_word  <= fill_value;   // R3
                        fill_addr  <= '0;
                        pace_cnt   <= PACE_W'(PACE - 1);
                        block_busy <= 1'b1;
                    end
                end
                ST_FILL:
                begin
                    if (pace_cnt != '0)
                        pace_cnt <= pace_cnt - 1'b1;
                    else
                    begin
                        pace_cnt  <= PACE_W'(PACE - 1);
                        fill_addr <= fill_addr + 1'b1;  // R1
                    end
                    if (fill_last)
                    begin
                        state      <= ST_IDLE;
                        reset_busy <= 1'b0;
                        block_busy <= 1'b0;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // connection memory write port
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cm_wr <= '0;
        else if (clk_en)
        begin
            cm_wr.we   <= state == ST_FILL && pace_cnt == '0;  // R1
            cm_wr.addr <= 15'(fill_addr);
            cm_wr.data <= fill_word;                // R3
        end
    end

    // tdm high impedance during block fill
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            tdm_hiz <= 1'b1;
        else if (clk_en)
            tdm_hiz <= start_req
                       || (state == ST_FILL && !fill_last);  // R10
    end

    // interrupt status, write one to clear, set wins
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_BLOCK_DONE] = fill_done && block_busy;
        irq_set[IRQ_RESET_DONE] = fill_done && reset_busy;
        irq_set[IRQ_BUS_FAULT]  = acc_fault;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_status <= '0;
        else if (clk_en)
        begin
            if (bus_req && write && hit_stat)
                irq_status <= (irq_status & ~writedata[IRQ_W-1:0])
                              | irq_set;
            else
                irq_status <= irq_status | irq_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask <= '0;
        else if (clk_en && bus_req && write && hit_mask)
            irq_mask <= writedata[IRQ_W-1:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |((irq_status | irq_set) & irq_mask);
    end

    // bus answer, one wait cycle then data
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitrequest   <= 1'b1;
            readdata      <= '0;
            response      <= 2'b00;
            bus_fault_out <= 1'b0;
        end
        else if (clk_en)
        begin
            waitrequest   <= !bus_req;
            bus_fault_out <= acc_fault;             // R9
            response      <= 2'b00;
            readdata      <= '0;
            if (bus_req)
            begin
                if (acc_fault)
                    response <= 2'b10;              // R9
                else if (!(hit_value || hit_trig || hit_stat
                           || hit_mask || hit_mem))
                    response <= 2'b11;
                if (read && hit_value)
                    readdata <= fill_value;
                else if (read && hit_trig)
                begin
                    readdata[BIT_BLOCK_BUSY] <= block_busy;  // R6 R8
                    readdata[BIT_RESET_BUSY] <= reset_busy;  // R7
                end
                else if (read && hit_stat)
                    readdata[IRQ_W-1:0] <= irq_status;
                else if (read && hit_mask)
                    readdata[IRQ_W-1:0] <= irq_mask;
            end
        end
    end

    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_start_on_key: assert property (  // R4
        start_req && clk_en |=> block_busy && state == ST_FILL)
        else $error("key did not start fill");
    a_busy_ignores_key: assert property (  // R5
        state == ST_FILL && clk_en |=> $stable(fill_word))
        else $error("fill word changed during fill");
    a_hiz_in_fill: assert property (  // R10
        block_busy && clk_en && !fill_last |=> tdm_hiz)
        else $error("tdm not high impedance during fill");
    a_fault_in_fill: assert property (  // R9
        acc_fault |=> bus_fault_out && response == 2'b10)
        else $error("no bus fault during fill");
    a_trig_upper_zero: assert property (  // R8
        !waitrequest |-> readdata[31:2] == '0 || !$past(hit_trig))
        else $error("trigger upper bits not zero");
    a_bad_key_quiet: assert property (  // R11
        bus_req && write && hit_trig && writedata != FILL_KEY
        && state == ST_IDLE |=> !block_busy)
        else $error("non key write started fill");
    a_reset_bit_once: assert property (  // R7
        !reset_busy |=> !reset_busy)
        else $error("reset busy rose again");
    a_fill_writes: assert property (  // R1
        cm_wr.we |-> cm_wr.data == fill_word)
        else $error("fill write data wrong");
    a_trig_busy_read: assert property (  // R6
        bus_req && read && hit_trig
        |=> readdata[BIT_BLOCK_BUSY] == $past(block_busy))
        else $error("block busy bit wrong");
    a_trig_reset_read: assert property (  // R7
        bus_req && read && hit_trig
        |=> readdata[BIT_RESET_BUSY] == $past(reset_busy))
        else $error("reset busy bit wrong");
    a_done_releases: assert property (  // R10
        fill_done && clk_en |=> state == ST_IDLE && !tdm_hiz)
        else $error("fill end did not release tdm");
    a_reset_fill_zero: assert property (  // R2
        reset_busy && cm_wr.we |-> cm_wr.data == FILL_RESET_VAL)
        else $error("reset fill word not zero");
    a_fault_pulse: assert property (  // R9
        bus_fault_out && clk_en |=> !bus_fault_out)
        else $error("bus fault longer than one cycle");
    a_one_wait: assert property (
        bus_req |=> !waitrequest)
        else $error("access not answered");
    a_wait_released: assert property (
        !waitrequest && clk_en |=> waitrequest)
        else $error("answer longer than one cycle");
    a_status_sticky: assert property (
        clk_en && !(bus_req && write && hit_stat)
        |=> (irq_status & $past(irq_status)) == $past(irq_status))
        else $error("status bit lost without clear");

    // cover points
    c_block_fill: cover property (fill_done && block_busy);
    c_reset_fill: cover property (fill_done && reset_busy);
    c_key_in_fill: cover property (bus_req && write && hit_trig
                                   && writedata == FILL_KEY
                                   && state == ST_FILL);
    c_bad_key: cover property (bus_req && write && hit_trig
                               && writedata != FILL_KEY);
    c_fault: cover property (acc_fault);
endmodule : cm_block_fill
`default_nettype wire

// ### common/fill_pkg.sv
// package for the connection memory block fill controller
package fill_pkg;
    localparam logic [23:0] OFS_FILL_VALUE  = 24'h04_0288;
    localparam logic [23:0] OFS_FILL_TRIG   = 24'h04_028c;
    localparam logic [23:0] OFS_IRQ_STATUS  = 24'h04_0290;
    localparam logic [23:0] OFS_IRQ_MASK    = 24'h04_0294;
    localparam logic [23:0] OFS_MEM_ACCESS  = 24'h04_0298;
    localparam logic [31:0] FILL_KEY        = 32'h3141_5926;
    localparam int          BIT_BLOCK_BUSY  = 0;
    localparam int          BIT_RESET_BUSY  = 1;
    localparam int          IRQ_BLOCK_DONE  = 0;
    localparam int          IRQ_RESET_DONE  = 1;
    localparam int          IRQ_BUS_FAULT   = 2;
    localparam int          IRQ_W           = 3;
    localparam logic [31:0] FILL_RESET_VAL  = 32'h0000_0000;
    localparam int          FILL_TIME_NS    = 120000;
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          FILL_CYCLES     = (FILL_TIME_NS * 1000)
                                              / CLK_PERIOD_PS;

    typedef enum {ST_IDLE, ST_FILL} fill_state_t;

    typedef struct packed {
        logic        we;
        logic [14:0] addr;
        logic [31:0] data;
    } cm_write_t;
endpackage : fill_pkg

// ### testbench/host_model.sv
// host model driving avalon-mm accesses
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input  wire logic        clk_sys,
    // avalon-mm master
    output logic      [23:0] address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic [1:0]  response,
    input  wire logic        waitrequest,
    input  wire logic        bus_fault_out
);
    logic [31:0] rd_q;
    logic [1:0]  rsp_q;
    logic        flt_q;
    initial
    begin
        address    = 24'h00_0000;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0000_0000;
        byteenable = 4'hf;
    end
    // one access, held until waitrequest is sampled low
    task acc(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        address   <= a;
        write     <= w;
        read      <= !w;
        writedata <= d;
        do
        begin
            @(posedge clk_sys);
        end
        while (waitrequest !== 1'b0);
        rd_q      = readdata;
        rsp_q     = response;
        flt_q     = bus_fault_out;
        read      <= 1'b0;
        write     <= 1'b0;
        address   <= ~a;
        writedata <= ~d;
    endtask : acc
endmodule : host_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking testbench for the block fill controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fill_pkg::*;
    localparam int DEPTH  = 16;
    localparam int CYCLES = 32;
    logic              clk_sys;
    logic              rst_n;
    logic              clk_en;
    logic [23:0]       address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
    logic [31:0]       readdata;
    logic [1:0]        response;
    logic              waitrequest;
    cm_write_t         cm_wr;
    logic              tdm_hiz;
    logic              bus_fault_out;
    logic              irq;
    logic [DEPTH-1:0]  seen;
    logic [31:0]       exp_fill;
    logic [31:0]       v;
    int                num_errors;
    int                n_checks;
    int                wr_cnt;

    cm_block_fill #(.DEPTH(DEPTH), .CYCLES(CYCLES)) u_cm_block_fill (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .cm_wr(cm_wr), .tdm_hiz(tdm_hiz),
        .bus_fault_out(bus_fault_out), .irq(irq));
    host_model u_host_model (
        .clk_sys(clk_sys), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .bus_fault_out(bus_fault_out));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task rd(input logic [23:0] a, input logic [31:0] e, input string name);
        u_host_model.acc(1'b0, a, 32'h0000_0000);
        chk(name, e, u_host_model.rd_q);
    endtask : rd

    task wr(input logic [23:0] a, input logic [31:0] d);
        u_host_model.acc(1'b1, a, d);
    endtask : wr

    task mem_try;
        u_host_model.acc(1'b0, OFS_MEM_ACCESS, 32'h0000_0000);
        chk("fault rsp", 32'h0000_0002, 32'(u_host_model.rsp_q));
        chk("fault pin", 32'h0000_0001, 32'(u_host_model.flt_q));
    endtask : mem_try

    task wait_idle;
        int n;
        n = 0;
        do
        begin
            u_host_model.acc(1'b0, OFS_FILL_TRIG, 32'h0000_0000);
            n++;
        end
        while (u_host_model.rd_q !== 32'h0000_0000 && n < 200);
        chk("fill count", 32'(DEPTH), 32'(wr_cnt));
        chk("fill cover", 32'((1 << DEPTH) - 1), 32'(seen));
        chk("hiz idle", 32'h0000_0000, 32'(tdm_hiz));
        wr_cnt = 0;
        seen   = '0;
    endtask : wait_idle

    always @(posedge clk_sys)
        if (cm_wr.we === 1'b1 && clk_en === 1'b1)
        begin
            chk("fill word", exp_fill, cm_wr.data);
            seen[cm_wr.addr[$clog2(DEPTH)-1:0]] = 1'b1;
            wr_cnt++;
        end

    initial
    begin
        #80000;
        num_errors++;
        stop_test();
    end

    initial
    begin
        rst_n      = 1'b0;
        clk_en     = 1'b1;
        exp_fill   = 32'h0000_0000;
        seen       = '0;
        wr_cnt     = 0;
        num_errors = 0;
        n_checks   = 0;
        v          = $urandom(94);
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(OFS_FILL_TRIG, 32'h0000_0002, "reset busy");
        chk("hiz reset", 32'h0000_0001, 32'(tdm_hiz));
        mem_try();
        wait_idle();
        rd(OFS_IRQ_STATUS, 32'h0000_0006, "irq status");
        chk("irq masked", 32'h0000_0000, 32'(irq));
        wr(OFS_IRQ_STATUS, 32'h0000_0007);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        for (int i = 0; i < 3; i++)
        begin
            v = (i == 0) ? 32'hffff_ffff : $urandom;
            wr(OFS_FILL_VALUE, v);
            rd(OFS_FILL_VALUE, v, "fill value");
            wr(OFS_FILL_TRIG, FILL_KEY ^ (v | 32'h0000_0001));
            rd(OFS_FILL_TRIG, 32'h0000_0000, "no start");
            exp_fill = v;
            wr(OFS_FILL_TRIG, FILL_KEY);
            chk("hiz fill", 32'h0000_0001, 32'(tdm_hiz));
            rd(OFS_FILL_TRIG, 32'h0000_0001, "block busy");
            wr(OFS_FILL_VALUE, ~v);
            wr(OFS_FILL_TRIG, FILL_KEY);
            mem_try();
            if (i == 1)
            begin
                clk_en <= 1'b0;
                repeat (5) @(posedge clk_sys);
                chk("hiz frozen", 32'h0000_0001, 32'(tdm_hiz));
                clk_en <= 1'b1;
            end
            wait_idle();
            chk("irq raised", 32'h0000_0001, 32'(irq));
            rd(OFS_IRQ_STATUS, 32'h0000_0005, "irq status");
            wr(OFS_IRQ_STATUS, 32'h0000_0007);
            rd(OFS_IRQ_STATUS, 32'h0000_0000, "irq clear");
            chk("irq low", 32'h0000_0000, 32'(irq));
        end
        wr(24'h00_0000, 32'h0000_0000);
        chk("unmapped", 32'h0000_0003, 32'(u_host_model.rsp_q));
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
